/* File: src/amm_pkg.sv */
package amm_pkg;

  // ==========================================================
  // Register indexes (byte address is four times the index)
  // ==========================================================
  localparam logic [15:0] IDX_ROM_OPERAND_HI = 16'hFF00;
  localparam logic [15:0] IDX_ROM_OPCODE_HI  = 16'hFF01;
  localparam logic [15:0] IDX_PROG_ONE_BASE  = 16'hFF02;
  localparam logic [15:0] IDX_PROG_TWO_BASE  = 16'hFF08;
  localparam logic [15:0] IDX_STATUS         = 16'hFF20;

  // Offsets inside one programmable mapper block
  localparam logic [2:0]  OFS_TARGET_LOW     = 3'h0;
  localparam logic [2:0]  OFS_TARGET_MID     = 3'h1;
  localparam logic [2:0]  OFS_OPERAND_HI     = 3'h2;
  localparam logic [2:0]  OFS_ZONE_SRC       = 3'h3;
  localparam logic [2:0]  OFS_CONTROL        = 3'h4;
  localparam logic [2:0]  OFS_OPCODE_HI      = 3'h5;

  // ==========================================================
  // Control register layout
  // ==========================================================
  localparam int          CTL_ENABLE_BIT     = 5;
  localparam int          CTL_SIZE_MSB       = 4;
  localparam logic [7:0]  CTL_RESET          = 8'h00;
  localparam logic [7:0]  BYTE_RESET         = 8'h00;

  // ==========================================================
  // Zone sizes
  // ==========================================================
  localparam logic [4:0]  SIZE_EXP_MIN       = 5'h08;
  localparam logic [4:0]  SIZE_EXP_MAX       = 5'h10;
  localparam logic [4:0]  ROM_SIZE_EXP       = 5'h0A;

  // ==========================================================
  // Matching mapper codes
  // ==========================================================
  localparam logic [1:0]  HIT_ROM            = 2'h0;
  localparam logic [1:0]  HIT_PROG_ONE       = 2'h1;
  localparam logic [1:0]  HIT_PROG_TWO       = 2'h2;

endpackage

/* File: src/amm_zone_mapper.sv */
`timescale 1ns/1ps
module amm_zone_mapper #(
  parameter bit ALWAYS_MATCH = 1'b0
) (
  // Logical access
  input  wire logic [15:0] log_addr,
  input  wire logic        opcode_fetch,
  // Configuration
  input  wire logic        enable,
  input  wire logic [7:0]  zone_addr,
  input  wire logic [4:0]  size_exp,
  input  wire logic [15:0] target_low,
  input  wire logic [7:0]  operand_hi,
  input  wire logic [7:0]  opcode_hi,
  // Result
  output logic             hit,
  output logic [31:0]      phys_addr
);

  logic [4:0]  exp_c;
  logic [16:0] mask;
  logic [7:0]  mask_hi;

  // ==========================================================
  // Mask from zone exponent
  // ==========================================================
  always_comb
  begin
    exp_c = size_exp;
    if (size_exp < amm_pkg::SIZE_EXP_MIN)
    begin
      exp_c = amm_pkg::SIZE_EXP_MIN;
    end
    else if (size_exp > amm_pkg::SIZE_EXP_MAX)
    begin
      exp_c = amm_pkg::SIZE_EXP_MAX;
    end
    mask    = (17'h00001 << exp_c) - 17'h00001;
    mask_hi = mask[15:8];
  end

  // ==========================================================
  // Match and translate
  // ==========================================================
  always_comb
  begin
    // Upper byte compared, masked bits ignored, zone naturally aligned
    hit = ALWAYS_MATCH | (enable & (((log_addr[15:8] ^ zone_addr) & ~mask_hi) == 8'h00));
    phys_addr[7:0]   = log_addr[7:0];
    phys_addr[15:8]  = (log_addr[15:8] & mask_hi) | (target_low[7:0] & ~mask_hi);
    phys_addr[23:16] = target_low[15:8];
    phys_addr[31:24] = opcode_fetch ? opcode_hi : operand_hi;
  end

endmodule

/* File: src/amm_code_mapper.sv */
`timescale 1ns/1ps
// Function
// - zone sizes are powers of two from 256 bytes to 64K bytes.
// - a zone starts at a multiple of its own size.
// - code mappers react to instruction fetches only.
// - compare upper logical byte with zone address, ignoring masked positions.
// - translated address is driven only when enabled and matching.
// - low logical byte passes unchanged to the physical address.
// - masked bits from logical address, others from the 24-bit target.
// - non-matching mapper defers to next lower; lowest always matches.
// - dedicated resources decode bits 23..0; 31..24 may carry debug tags.
// - each programmable mapper holds zone byte, size exponent, 24-bit target, enable.
// - mask is two to the exponent minus one; exponent kept 8..16.
// - priority: programmable two, programmable one, ROM; only ROM always enabled.
// - 1K boot ROM repeats as 64 images at every 1K boundary.
// - ROM hit takes upper byte from operand or opcode tag register.
// - after reset the ROM is reachable by fetches with no setup.
// - internal RAM and internal special registers are never forwarded.
// - reset leaves both programmable code mappers disabled.
module amm_code_mapper #(
  parameter logic [23:0] ROM_BASE = 24'h000000
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Core access
  input  wire logic        core_valid,
  input  wire logic        core_code,
  input  wire logic        core_external,
  input  wire logic        core_opcode,
  input  wire logic [15:0] core_addr,
  // System bus request
  output logic             bus_req_q,
  output logic [31:0]      bus_addr_q,
  output logic [1:0]       bus_hit_q
);

  localparam int NPROG = 2;

  generate
    if (ROM_BASE[9:0] != 10'h000)
    begin : g_chk
      $error("ROM_BASE must be aligned to 1K");
    end
  endgenerate

  // ==========================================================
  // Configuration storage
  // ==========================================================
  logic [7:0]  rom_operand_target_high_q;
  logic [7:0]  rom_opcode_target_high_q;
  logic [7:0]  tgt_low_q  [NPROG];
  logic [7:0]  tgt_mid_q  [NPROG];
  logic [7:0]  operand_q  [NPROG];
  logic [7:0]  opcode_q   [NPROG];
  logic [7:0]  zone_q     [NPROG];
  logic [7:0]  ctl_q      [NPROG];

  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [1:0]  status_hit_q;

  logic [15:0] reg_idx;
  logic        idx_ok;
  logic        wr_en;
  logic [7:0]  rd_byte;
  logic        rd_hit;

  assign reg_idx = paddr[17:2];
  assign idx_ok  = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'h0);
  assign wr_en   = psel & penable & pwrite & pready_q;

  // ==========================================================
  // Read decode
  // ==========================================================
  always_comb
  begin
    logic [15:0] base;
    base    = 16'h0000;
    rd_byte = 8'h00;
    rd_hit  = 1'b0;
    if (idx_ok)
    begin
      if (reg_idx == amm_pkg::IDX_ROM_OPERAND_HI)
      begin
        rd_byte = rom_operand_target_high_q;
        rd_hit  = 1'b1;
      end
      else if (reg_idx == amm_pkg::IDX_ROM_OPCODE_HI)
      begin
        rd_byte = rom_opcode_target_high_q;
        rd_hit  = 1'b1;
      end
      else if (reg_idx == amm_pkg::IDX_STATUS)
      begin
        rd_byte = {6'h00, status_hit_q};
        rd_hit  = 1'b1;
      end
      for (int m = 0; m < NPROG; m++)
      begin
        base = (m == 0) ? amm_pkg::IDX_PROG_ONE_BASE : amm_pkg::IDX_PROG_TWO_BASE;
        if (reg_idx == base + {13'h0000, amm_pkg::OFS_TARGET_LOW})
        begin
          rd_byte = tgt_low_q[m];
          rd_hit  = 1'b1;
        end
        if (reg_idx == base + {13'h0000, amm_pkg::OFS_TARGET_MID})
        begin
          rd_byte = tgt_mid_q[m];
          rd_hit  = 1'b1;
        end
        if (reg_idx == base + {13'h0000, amm_pkg::OFS_OPERAND_HI})
        begin
          rd_byte = operand_q[m];
          rd_hit  = 1'b1;
        end
        if (reg_idx == base + {13'h0000, amm_pkg::OFS_ZONE_SRC})
        begin
          rd_byte = zone_q[m];
          rd_hit  = 1'b1;
        end
        if (reg_idx == base + {13'h0000, amm_pkg::OFS_CONTROL})
        begin
          rd_byte = ctl_q[m];
          rd_hit  = 1'b1;
        end
        if (reg_idx == base + {13'h0000, amm_pkg::OFS_OPCODE_HI})
        begin
          rd_byte = opcode_q[m];
          rd_hit  = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // APB response: one wait cycle, then pready
  // ==========================================================
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= psel & penable & ~pready_q;
      if (psel & penable & ~pready_q)
      begin
        prdata_q  <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
        pslverr_q <= ~rd_hit | (pwrite & (reg_idx == amm_pkg::IDX_STATUS));
      end
      else
      begin
        prdata_q  <= 32'h00000000;
        pslverr_q <= 1'b0;
      end
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // ==========================================================
  // ROM tag registers
  // ==========================================================
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rom_operand_target_high_q <= amm_pkg::BYTE_RESET;
      rom_opcode_target_high_q  <= amm_pkg::BYTE_RESET;
    end
    else if (wr_en && idx_ok)
    begin
      if (reg_idx == amm_pkg::IDX_ROM_OPERAND_HI)
      begin
        rom_operand_target_high_q <= pwdata[7:0];
      end
      if (reg_idx == amm_pkg::IDX_ROM_OPCODE_HI)
      begin
        rom_opcode_target_high_q <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Programmable mapper registers
  // ==========================================================
  logic        prog_hit  [NPROG];
  logic [31:0] prog_phys [NPROG];

  generate
    for (genvar g = 0; g < NPROG; g++)
    begin : g_prog
      localparam logic [15:0] BASE = (g == 0) ? amm_pkg::IDX_PROG_ONE_BASE : amm_pkg::IDX_PROG_TWO_BASE;

      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          tgt_low_q[g] <= amm_pkg::BYTE_RESET;
          tgt_mid_q[g] <= amm_pkg::BYTE_RESET;
          operand_q[g] <= amm_pkg::BYTE_RESET;
          opcode_q[g]  <= amm_pkg::BYTE_RESET;
          zone_q[g]    <= amm_pkg::BYTE_RESET;
          ctl_q[g]     <= amm_pkg::CTL_RESET;
        end
        else if (wr_en && idx_ok)
        begin
          if (reg_idx == BASE + {13'h0000, amm_pkg::OFS_TARGET_LOW})
          begin
            tgt_low_q[g] <= pwdata[7:0];
          end
          if (reg_idx == BASE + {13'h0000, amm_pkg::OFS_TARGET_MID})
          begin
            tgt_mid_q[g] <= pwdata[7:0];
          end
          if (reg_idx == BASE + {13'h0000, amm_pkg::OFS_OPERAND_HI})
          begin
            operand_q[g] <= pwdata[7:0];
          end
          if (reg_idx == BASE + {13'h0000, amm_pkg::OFS_ZONE_SRC})
          begin
            zone_q[g] <= pwdata[7:0];
          end
          if (reg_idx == BASE + {13'h0000, amm_pkg::OFS_CONTROL})
          begin
            ctl_q[g] <= {2'h0, pwdata[5:0]};
          end
          if (reg_idx == BASE + {13'h0000, amm_pkg::OFS_OPCODE_HI})
          begin
            opcode_q[g] <= pwdata[7:0];
          end
        end
      end

      amm_zone_mapper #(
        .ALWAYS_MATCH (1'b0)
      ) u_prog (
        .log_addr     (core_addr),
        .opcode_fetch (core_opcode),
        .enable       (ctl_q[g][amm_pkg::CTL_ENABLE_BIT]),
        .zone_addr    (zone_q[g]),
        .size_exp     (ctl_q[g][amm_pkg::CTL_SIZE_MSB:0]),
        .target_low   ({tgt_mid_q[g], tgt_low_q[g]}),
        .operand_hi   (operand_q[g]),
        .opcode_hi    (opcode_q[g]),
        .hit          (prog_hit[g]),
        .phys_addr    (prog_phys[g])
      );
    end
  endgenerate

  // ==========================================================
  // ROM mapper: always enabled, 1K images repeat everywhere
  // ==========================================================
  logic        rom_hit;
  logic [31:0] rom_phys;

  amm_zone_mapper #(
    .ALWAYS_MATCH (1'b1)
  ) u_rom (
    .log_addr     (core_addr),
    .opcode_fetch (core_opcode),
    .enable       (1'b1),
    .zone_addr    (8'h00),
    .size_exp     (amm_pkg::ROM_SIZE_EXP),
    .target_low   (ROM_BASE[23:8]),
    .operand_hi   (rom_operand_target_high_q),
    .opcode_hi    (rom_opcode_target_high_q),
    .hit          (rom_hit),
    .phys_addr    (rom_phys)
  );

  // ==========================================================
  // Priority select and registered bus request
  // ==========================================================
  logic [31:0] sel_phys;
  logic [1:0]  sel_hit;

  always_comb
  begin
    sel_phys = rom_phys;
    sel_hit  = amm_pkg::HIT_ROM;
    if (prog_hit[1])
    begin
      sel_phys = prog_phys[1];
      sel_hit  = amm_pkg::HIT_PROG_TWO;
    end
    else if (prog_hit[0])
    begin
      sel_phys = prog_phys[0];
      sel_hit  = amm_pkg::HIT_PROG_ONE;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      bus_req_q    <= 1'b0;
      bus_addr_q   <= 32'h00000000;
      bus_hit_q    <= amm_pkg::HIT_ROM;
      status_hit_q <= amm_pkg::HIT_ROM;
    end
    else
    begin
      // Only external code fetches leave the core
      bus_req_q <= core_valid & core_code & core_external & rom_hit;
      if (core_valid & core_code & core_external)
      begin
        bus_addr_q   <= sel_phys;
        bus_hit_q    <= sel_hit;
        status_hit_q <= sel_hit;
      end
    end
  end

endmodule

/* File: verification/amm_code_mapper_assertions.sv */
`timescale 1ns/1ps
// ==========
// Port checker
module amm_code_mapper_assertions #(
  parameter logic [23:0] ROM_BASE = 24'h000000
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Bus handshake
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // Core and system bus
  input wire logic        core_valid,
  input wire logic        core_code,
  input wire logic        core_external,
  input wire logic [15:0] core_addr,
  input wire logic        bus_req_q,
  input wire logic [31:0] bus_addr_q,
  input wire logic [1:0]  bus_hit_q
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_REQ_CAUSE: assert property (bus_req_q |-> $past(core_valid && core_code && core_external))
    else $error("bus request without external code fetch");
  AST_REQ_LATENCY: assert property (core_valid && core_code && core_external |=> bus_req_q)
    else $error("fetch not forwarded next cycle");
  AST_LOW_BYTE: assert property (bus_req_q |-> bus_addr_q[7:0] == $past(core_addr[7:0]))
    else $error("low address byte altered");
  AST_ADDR_HOLD: assert property (!bus_req_q |-> $stable(bus_addr_q) && $stable(bus_hit_q))
    else $error("address changed without request");
  AST_ROM_IMAGE: assert property (bus_req_q && bus_hit_q == amm_pkg::HIT_ROM |->
    bus_addr_q[23:10] == ROM_BASE[23:10] && bus_addr_q[9:0] == $past(core_addr[9:0]))
    else $error("rom image address wrong");
  AST_HIT_CODE: assert property (bus_req_q |-> bus_hit_q != 2'h3)
    else $error("unknown mapper code");
  AST_APB_WAIT: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_RESET_CLEAR: assert property ($past(!rst_n) |-> !bus_req_q && bus_hit_q == amm_pkg::HIT_ROM)
    else $error("outputs not cleared by reset");
endmodule

bind amm_code_mapper amm_code_mapper_assertions #(.ROM_BASE(ROM_BASE)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
  .core_valid(core_valid), .core_code(core_code), .core_external(core_external),
  .core_addr(core_addr), .bus_req_q(bus_req_q), .bus_addr_q(bus_addr_q), .bus_hit_q(bus_hit_q)
);

/* File: verification/amm_sysbus_model.sv */
`timescale 1ns/1ps
// ==========
// System bus sink
module amm_sysbus_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Request
  input  wire logic        bus_req_q,
  input  wire logic [31:0] bus_addr_q,
  // Observed
  output logic [15:0]      n_req_q,
  output logic [23:0]      dec_addr_q
);
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      n_req_q    <= 16'h0000;
      dec_addr_q <= 24'h000000;
    end
    else if (bus_req_q)
    begin
      n_req_q    <= n_req_q + 16'h0001;
      dec_addr_q <= bus_addr_q[23:0];
    end
  end
endmodule

/* File: verification/mcu_address_mapper_tb.sv */
`timescale 1ns/1ps
module mcu_address_mapper_tb;
  typedef struct packed {logic [15:0] a; logic o; logic [1:0] h; logic [31:0] pa;} amm_row_type;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic        pready, pslverr, bus_req_q;
  logic        core_valid = 1'b0, core_code = 1'b0, core_external = 1'b0, core_opcode = 1'b0;
  logic [15:0] core_addr = 16'h0, n_req_q;
  logic [31:0] bus_addr_q;
  logic [1:0]  bus_hit_q;
  logic [23:0] dec_addr_q;
  int          n_errors = 0, checks = 0, cyc = 0;
  logic [7:0]  cfg [14] = '{8'hA5, 8'h5A, 8'h12, 8'h80, 8'h11, 8'h40, 8'h2C,
                            8'h22, 8'hC0, 8'h10, 8'h33, 8'h43, 8'h28, 8'h44};
  amm_row_type rows [8] = '{'{16'h4321, 1'b0, 2'h2, 32'h3310C021}, '{16'h4321, 1'b1, 2'h2, 32'h4410C021},
                            '{16'h4A55, 1'b0, 2'h1, 32'h11801A55}, '{16'h4FFF, 1'b1, 2'h1, 32'h22801FFF},
                            '{16'h5000, 1'b0, 2'h0, 32'hA5000000}, '{16'hFFFF, 1'b1, 2'h0, 32'h5A0003FF},
                            '{16'h3C17, 1'b0, 2'h0, 32'hA5000017}, '{16'h4400, 1'b0, 2'h1, 32'h11801400}};

  amm_code_mapper dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .core_valid(core_valid), .core_code(core_code), .core_external(core_external), .core_opcode(core_opcode),
    .core_addr(core_addr), .bus_req_q(bus_req_q), .bus_addr_q(bus_addr_q), .bus_hit_q(bus_hit_q));
  amm_sysbus_model u_bus (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req_q(bus_req_q), .bus_addr_q(bus_addr_q),
    .n_req_q(n_req_q), .dec_addr_q(dec_addr_q));

  always #2 clk_sys = ~clk_sys;

  function automatic logic [31:0] ra(input logic [15:0] i);
    return {14'h0, i, 2'h0};
  endfunction

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [34:0] s, input logic [34:0] e);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // ==========
  // Bus cycles
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [31:0] er,
                     input logic ee);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // Wait for ready; only the bench timeout ends a hung transfer
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    chk({2'h0, pslverr, prdata}, {2'h0, ee, er});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic fetch(input logic [15:0] a, input logic o, c, x, r, input logic [1:0] h,
                       input logic [31:0] pa);
    @(posedge clk_sys);
    core_valid    <= 1'b1;
    core_code     <= c;
    core_external <= x;
    core_opcode   <= o;
    core_addr     <= a;
    @(posedge clk_sys);
    core_valid <= 1'b0;
    #1;
    chk({bus_req_q, bus_hit_q, bus_addr_q}, {r, h, pa});
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      n_errors++;
      end_sim();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    chk({pready, pslverr, bus_req_q, bus_addr_q}, 35'h0);
    rst_n <= 1'b1;
    apb(1'b0, ra(amm_pkg::IDX_ROM_OPERAND_HI), 8'h00, 32'h0, 1'b0);
    apb(1'b0, ra(amm_pkg::IDX_PROG_ONE_BASE + 16'h4), 8'h00, 32'h0, 1'b0);
    apb(1'b0, ra(amm_pkg::IDX_PROG_TWO_BASE + 16'h4), 8'h00, 32'h0, 1'b0);
    fetch(16'h1234, 1'b1, 1'b1, 1'b1, 1'b1, amm_pkg::HIT_ROM, 32'h00000234);
    for (int i = 0; i < 14; i++)
      apb(1'b1, ra(amm_pkg::IDX_ROM_OPERAND_HI + i[15:0]), cfg[i], 32'h0, 1'b0);
    for (int i = 0; i < 14; i++)
      apb(1'b0, ra(amm_pkg::IDX_ROM_OPERAND_HI + i[15:0]), 8'h00, {24'h0, cfg[i]}, 1'b0);
    foreach (rows[i])
      fetch(rows[i].a, rows[i].o, 1'b1, 1'b1, 1'b1, rows[i].h, rows[i].pa);
    // Status, read-only and unmapped places
    apb(1'b0, ra(amm_pkg::IDX_STATUS), 8'h00, 32'h1, 1'b0);
    apb(1'b1, ra(amm_pkg::IDX_STATUS), 8'h03, 32'h0, 1'b1);
    apb(1'b0, ra(amm_pkg::IDX_STATUS), 8'h00, 32'h1, 1'b0);
    apb(1'b0, ra(16'hFF10), 8'h00, 32'h0, 1'b1);
    apb(1'b0, ra(amm_pkg::IDX_ROM_OPERAND_HI) + 32'h1, 8'h00, 32'h0, 1'b1);
    // Data and internal accesses stay off the bus
    fetch(16'h4321, 1'b0, 1'b0, 1'b1, 1'b0, 2'h1, 32'h11801400);
    fetch(16'h4321, 1'b0, 1'b1, 1'b0, 1'b0, 2'h1, 32'h11801400);
    chk({19'h0, n_req_q}, 35'h9);
    chk({11'h0, dec_addr_q}, 35'h801400);
    apb(1'b1, ra(amm_pkg::IDX_PROG_TWO_BASE + 16'h4), 8'h08, 32'h0, 1'b0);
    fetch(16'h4321, 1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 32'h11801321);
    apb(1'b1, ra(amm_pkg::IDX_PROG_ONE_BASE + 16'h4), 8'h30, 32'h0, 1'b0);
    fetch(16'hBEEF, 1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 32'h1180BEEF);
    apb(1'b1, ra(amm_pkg::IDX_PROG_ONE_BASE + 16'h4), 8'h10, 32'h0, 1'b0);
    fetch(16'hBEEF, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 32'h5A0002EF);
    // Reset in mid-run, with a mapper enabled that matches everything
    apb(1'b1, ra(amm_pkg::IDX_PROG_ONE_BASE + 16'h4), 8'h30, 32'h0, 1'b0);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({pready, pslverr, bus_req_q, bus_addr_q}, 35'h0);
    chk({33'h0, bus_hit_q}, {33'h0, amm_pkg::HIT_ROM});
    rst_n <= 1'b1;
    apb(1'b0, ra(amm_pkg::IDX_PROG_ONE_BASE + 16'h4), 8'h00, 32'h0, 1'b0);
    apb(1'b0, ra(amm_pkg::IDX_PROG_TWO_BASE + 16'h4), 8'h00, 32'h0, 1'b0);
    fetch(16'h47AB, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 32'h000003AB);
    end_sim();
  end
endmodule
